// >>> rtl/qdr_sram_ctrl.v
`timescale 1ns/1ps
`include "qdr_ctrl_regs.vh"
module qdr_sram_ctrl
#(
    parameter AW = 8,
    parameter DW = 18,
    parameter BW = 2,
    parameter LOCK_COUNT = `LOCK_CYCLES,
    parameter STOP_COUNT = `CLK_STOP_CYCLES,
    parameter TERM_OPTION2 = 0
)
(
    input wire core_clk,
    input wire rst_n,
    input wire clkTrue,
    input wire clkComp,
    input wire readSelN,
    input wire writeSelN,
    input wire [AW-1:0] readAddr,
    input wire [AW-1:0] writeAddr,
    input wire [DW-1:0] writeData,
    input wire [BW-1:0] byteWriteMaskN,
    input wire dllDisableN,
    input wire terminationSelect,
    output reg [DW-1:0] readData,
    output reg readValidFlag,
    output reg echoClockTrue,
    output reg echoClockComp,
    output reg [3:0] impCode,
    output reg impSettled,
    output reg [1:0] termClkLevel,
    output reg [1:0] termDataLevel,
    output reg dllLocked,
    output reg deviceReady,
    output wire writeOverflow
);
    localparam BL = DW / BW;
    localparam AFULL = AW + 2;
    localparam RS_IDLE = 2'h0;
    localparam RS_WAIT = 2'h1;
    localparam RS_OUT = 2'h2;
    localparam WS_IDLE = 1'h0;
    localparam WS_DATA = 1'h1;

    // pin synchronisers
    reg [1:0] tSync_ff, cSync_ff, dSync_ff, oSync_ff;
    reg tPrev_ff, cPrev_ff, dPrev_ff;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tSync_ff <= 2'h0;
            cSync_ff <= 2'h0;
            dSync_ff <= 2'h0;
            oSync_ff <= 2'h3;
            tPrev_ff <= 1'b0;
            cPrev_ff <= 1'b0;
            dPrev_ff <= 1'b0;
        end
        else
        begin
            tSync_ff <= {tSync_ff[0], clkTrue};
            cSync_ff <= {cSync_ff[0], clkComp};
            dSync_ff <= {dSync_ff[0], dllDisableN};
            oSync_ff <= {oSync_ff[0], terminationSelect};
            tPrev_ff <= tSync_ff[1];
            cPrev_ff <= cSync_ff[1];
            dPrev_ff <= dSync_ff[1];
        end
    end
    wire tRise = tSync_ff[1] && !tPrev_ff;
    wire cRise = cSync_ff[1] && !cPrev_ff;
    wire dllOn = dSync_ff[1];

    // command/data inputs sampled into core domain
    reg [1:0] rSelSync_ff, wSelSync_ff;
    reg [AW-1:0] rA1_ff, rA2_ff, wA1_ff, wA2_ff;
    reg [DW-1:0] wd1_ff, wd2_ff;
    reg [BW-1:0] bm1_ff, bm2_ff;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rSelSync_ff <= 2'h3;
            wSelSync_ff <= 2'h3;
            rA1_ff <= {AW{1'b0}};
            rA2_ff <= {AW{1'b0}};
            wA1_ff <= {AW{1'b0}};
            wA2_ff <= {AW{1'b0}};
            wd1_ff <= {DW{1'b0}};
            wd2_ff <= {DW{1'b0}};
            bm1_ff <= {BW{1'b1}};
            bm2_ff <= {BW{1'b1}};
        end
        else
        begin
            rSelSync_ff <= {rSelSync_ff[0], readSelN};
            wSelSync_ff <= {wSelSync_ff[0], writeSelN};
            rA1_ff <= readAddr;
            rA2_ff <= rA1_ff;
            wA1_ff <= writeAddr;
            wA2_ff <= wA1_ff;
            wd1_ff <= writeData;
            wd2_ff <= wd1_ff;
            bm1_ff <= byteWriteMaskN;
            bm2_ff <= bm1_ff;
        end
    end

    reg [10:0] impCnt_ff;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            impCnt_ff <= 11'h0;
            impCode <= `IMP_MID_CODE;
            impSettled <= 1'b0;
        end
        else if (!impSettled && tRise)
        begin
            impCnt_ff <= impCnt_ff + 11'h1;
            if (impCnt_ff == `IMP_SETTLE_CYCLES - 1)
            begin
                impSettled <= 1'b1;
                impCode <= 4'hf;
            end
        end
    end

    reg [3:0] stopCnt_ff;
    wire clkStopped = (stopCnt_ff >= STOP_COUNT);
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            stopCnt_ff <= 4'h0;
        else if (tRise || cRise)
            stopCnt_ff <= 4'h0;
        else if (!clkStopped)
            stopCnt_ff <= stopCnt_ff + 4'h1;
    end
    // loop reset on disable rise or stop
    wire dllReset = (dllOn && !dPrev_ff) || clkStopped;

    // lock count, ready after period, bypass still waits
    reg [11:0] lockCnt_ff;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lockCnt_ff <= 12'h0;
            dllLocked <= 1'b0;
            deviceReady <= 1'b0;
        end
        else if (dllReset)
        begin
            lockCnt_ff <= 12'h0;
            dllLocked <= 1'b0;
            deviceReady <= 1'b0;
        end
        else
        begin
            if (!dllOn)
                dllLocked <= 1'b0;
            if (tRise && !deviceReady)
            begin
                lockCnt_ff <= lockCnt_ff + 12'h1;
                if (lockCnt_ff == LOCK_COUNT[11:0] - 12'h1)
                begin
                    deviceReady <= 1'b1;
                    dllLocked <= dllOn;
                end
            end
        end
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            termClkLevel <= `TERM_OFF;
            termDataLevel <= `TERM_OFF;
        end
        else if (TERM_OPTION2 != 0)
        begin
            termClkLevel <= `TERM_OFF;
            termDataLevel <= oSync_ff[1] ? `TERM_WEAK : `TERM_OFF;
        end
        else
        begin
            termClkLevel <= oSync_ff[1] ? `TERM_WEAK : `TERM_STRONG;
            termDataLevel <= oSync_ff[1] ? `TERM_WEAK : `TERM_STRONG;
        end
    end

    // memory array and write buffers
    reg [DW-1:0] mem [0:(1<<AFULL)-1];
    wire fifoInReady;
    wire fifoOutValid;
    wire [AFULL+BW+DW-1:0] fifoOut;
    reg wbValid_ff;
    reg [AFULL+BW+DW-1:0] wbWord_ff;
    assign writeOverflow = wbValid_ff && !fifoInReady;
    data_fifo #(.WIDTH(AFULL+BW+DW), .DEPTH(32), .AW(5)) u_wbuf
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .inValid(wbValid_ff),
        .inReady(fifoInReady),
        .inData(wbWord_ff),
        .outValid(fifoOutValid),
        .outReady(1'b1),
        .outData(fifoOut)
    );
    wire [AFULL-1:0] cAddr = fifoOut[AFULL+BW+DW-1:BW+DW];
    wire [BW-1:0] cMask = fifoOut[BW+DW-1:DW];
    wire [DW-1:0] cData = fifoOut[DW-1:0];
    integer i;
    always @(posedge core_clk)
    begin
        if (fifoOutValid)
        begin
            for (i = 0; i < BW; i = i + 1)
            begin
                if (!cMask[i])
                    mem[cAddr][i*BL +: BL] <= cData[i*BL +: BL];
            end
        end
    end

    reg wState_ff;
    reg [AW-1:0] wBase_ff;
    reg [1:0] wBeat_ff;
    reg wCmdLast_ff;
    wire wSel = !wSelSync_ff[1];
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wState_ff <= WS_IDLE;
            wBase_ff <= {AW{1'b0}};
            wBeat_ff <= 2'h0;
            wCmdLast_ff <= 1'b0;
            wbValid_ff <= 1'b0;
            wbWord_ff <= {(AFULL+BW+DW){1'b0}};
        end
        else
        begin
            wbValid_ff <= 1'b0;
            if (tRise)
                wCmdLast_ff <= wSel && !wCmdLast_ff && wState_ff == WS_IDLE;
            case (wState_ff)
                WS_IDLE:
                begin
                    if (tRise && wSel && !wCmdLast_ff)
                    begin
                        wState_ff <= WS_DATA;
                        wBase_ff <= wA2_ff;
                        wBeat_ff <= 2'h0;
                    end
                end
                WS_DATA:
                begin
                    // beats from next true edge; linear
                    if (tRise || (cRise && !wCmdLast_ff))
                    begin
                        wbValid_ff <= 1'b1;
                        wbWord_ff <= {wBase_ff, wBeat_ff, bm2_ff, wd2_ff};
                        wBeat_ff <= wBeat_ff + 2'h1;
                        if (wBeat_ff == 2'h3)
                            wState_ff <= WS_IDLE;
                    end
                end
                default: wState_ff <= WS_IDLE;
            endcase
        end
    end

    reg [1:0] rState_ff;
    reg [AW-1:0] rBase_ff;
    reg [2:0] rEdge_ff;
    reg [1:0] rBeat_ff;
    reg rCmdLast_ff;
    wire rSel = !rSelSync_ff[1];
    wire [2:0] latEdges = dllOn ? 3'h4 : 3'h1;
    wire [AFULL-1:0] rdAddr = {rBase_ff, rBeat_ff};
    wire fwdHit = wbValid_ff && (wbWord_ff[AFULL+BW+DW-1:BW+DW] == rdAddr);
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rState_ff <= RS_IDLE;
            rBase_ff <= {AW{1'b0}};
            rEdge_ff <= 3'h0;
            rBeat_ff <= 2'h0;
            rCmdLast_ff <= 1'b0;
            readData <= {DW{1'b0}};
            readValidFlag <= 1'b0;
            echoClockTrue <= 1'b0;
            echoClockComp <= 1'b1;
        end
        else
        begin
            echoClockTrue <= tSync_ff[1];
            echoClockComp <= cSync_ff[1];
            if (tRise)
                rCmdLast_ff <= rSel && !rCmdLast_ff && rState_ff == RS_IDLE;
            case (rState_ff)
                RS_IDLE:
                begin
                    readValidFlag <= 1'b0;
                    if (tRise && rSel && !rCmdLast_ff && deviceReady)
                    begin
                        rState_ff <= RS_WAIT;
                        rBase_ff <= rA2_ff;
                        rEdge_ff <= 3'h0;
                        rBeat_ff <= 2'h0;
                    end
                end
                RS_WAIT:
                begin
                    if (tRise || cRise)
                    begin
                        rEdge_ff <= rEdge_ff + 3'h1;
                        // flag rises one half cycle ahead
                        if (rEdge_ff + 3'h1 == latEdges)
                        begin
                            readValidFlag <= 1'b1;
                            rState_ff <= RS_OUT;
                        end
                    end
                end
                RS_OUT:
                begin
                    if (tRise || cRise)
                    begin
                        readData <= fwdHit ? wbWord_ff[DW-1:0] : mem[rdAddr];
                        rBeat_ff <= rBeat_ff + 2'h1;
                        if (rBeat_ff == 2'h2)
                            readValidFlag <= 1'b0;
                        if (rBeat_ff == 2'h3)
                            rState_ff <= RS_IDLE;
                    end
                end
                default: rState_ff <= RS_IDLE;
            endcase
        end
    end
endmodule // qdr_sram_ctrl

// >>> rtl/qdr_ctrl_regs.vh
`ifndef QDR_CTRL_REGS_VH
`define QDR_CTRL_REGS_VH
`define IMP_SETTLE_CYCLES 1024
`define IMP_MID_CODE 4'h8
`define LOCK_CYCLES 2048
`define CLK_STOP_NS 30
`define CORE_PERIOD_NS 25
`define CLK_STOP_CYCLES ((`CLK_STOP_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define TERM_OFF 2'h0
`define TERM_WEAK 2'h1
`define TERM_STRONG 2'h2
`endif

// >>> rtl/data_fifo.v
`timescale 1ns/1ps
module data_fifo
#(
    parameter WIDTH = 18,
    parameter DEPTH = 32,
    parameter AW = 5
)
(
    input wire core_clk,
    input wire rst_n,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_ff;
    reg [AW:0] rdPtr_ff;
    wire full = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    wire empty = (wrPtr_ff == rdPtr_ff);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_ff[AW-1:0]];
    always @(posedge core_clk)
    begin
        if (inValid && !full)
            mem[wrPtr_ff[AW-1:0]] <= inData;
    end
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_ff <= {(AW+1){1'b0}};
            rdPtr_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (inValid && !full)
                wrPtr_ff <= wrPtr_ff + 1'b1;
            if (outReady && !empty)
                rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end
endmodule // data_fifo

// >>> verification/qdr_sram_ctrl_checker.sv
`timescale 1ns/1ps
module qdr_sram_ctrl_checker
#(
    parameter TERM_OPTION2 = 0
)
(
    input wire core_clk,
    input wire rst_n,
    input wire dllDisableN,
    input wire terminationSelect,
    input wire readValidFlag,
    input wire [3:0] impCode,
    input wire impSettled,
    input wire [1:0] termClkLevel,
    input wire [1:0] termDataLevel,
    input wire dllLocked,
    input wire deviceReady
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // core cycles since reset; 200 ns link clock gives 1024 link cycles near 8192
    reg [13:0] upCnt_ff;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            upCnt_ff <= 14'h0;
        else if (upCnt_ff != 14'h3fff)
            upCnt_ff <= upCnt_ff + 14'h1;
    end
    imp_mid_a: assert property ($rose(rst_n) |-> impCode == 4'h8)
        else $error("impedance not mid after reset");
    imp_early_a: assert property (upCnt_ff == 14'h1f40 |-> !impSettled && impCode == 4'h8)
        else $error("impedance settled too early");
    imp_final_a: assert property (upCnt_ff == 14'h20d0 |-> impSettled && impCode == 4'hf)
        else $error("impedance not settled in time");
    bypass_nolock_a: assert property ((!dllDisableN)[*4] |-> !dllLocked)
        else $error("loop locked while bypassed");
    lock_wait_a: assert property ($rose(dllLocked) |-> $past(dllDisableN, 8))
        else $error("lock without stable enable");
    ready_lock_a: assert property ($rose(deviceReady) |-> dllLocked || !dllDisableN)
        else $error("ready before lock");
    term_strong_a: assert property ((TERM_OPTION2 == 0 && !terminationSelect)[*4]
        |-> termClkLevel == 2'h2 && termDataLevel == 2'h2) else $error("strong level wrong");
    term_weak_a: assert property ((TERM_OPTION2 == 0 && terminationSelect)[*4]
        |-> termClkLevel == 2'h1 && termDataLevel == 2'h1) else $error("weak level wrong");
    flag_idle_a: assert property (!deviceReady |-> !readValidFlag)
        else $error("flag high while not ready");
    flag_span_a: assert property ($rose(readValidFlag)
        |-> readValidFlag[*8] ##[1:12] !readValidFlag) else $error("flag span wrong");
endmodule // qdr_sram_ctrl_checker

bind qdr_sram_ctrl qdr_sram_ctrl_checker #(.TERM_OPTION2(TERM_OPTION2)) chk
(
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dllDisableN(dllDisableN),
    .terminationSelect(terminationSelect),
    .readValidFlag(readValidFlag),
    .impCode(impCode),
    .impSettled(impSettled),
    .termClkLevel(termClkLevel),
    .termDataLevel(termDataLevel),
    .dllLocked(dllLocked),
    .deviceReady(deviceReady)
);

// >>> verification/memctl_model.sv
`timescale 1ns/1ps
module memctl_model
(
    output reg clkTrue = 1'b0,
    output reg clkComp = 1'b1,
    output reg readSelN = 1'b1,
    output reg writeSelN = 1'b1,
    output reg [7:0] readAddr = 8'h0,
    output reg [7:0] writeAddr = 8'h0,
    output reg [17:0] writeData = 18'h0,
    output reg [1:0] byteWriteMaskN = 2'h3
);
    reg run = 1'b1;
    realtime cmdTime = 0.0;
    initial
    begin
        #37;
        forever
        begin
            #100;
            if (run)
            begin
                clkTrue = ~clkTrue;
                clkComp = ~clkComp;
            end
        end
    end
    task cmd(input [0:0] rd, input [0:0] wr, input [7:0] ra, input [7:0] wa,
        input [17:0] b, input [1:0] m);
        integer i;
        begin
            @(negedge clkTrue);
            readSelN = ~rd;
            writeSelN = ~wr;
            readAddr = ra;
            writeAddr = wa;
            @(posedge clkTrue);
            cmdTime = $realtime;
            #50;
            readSelN = 1'b1;
            writeSelN = 1'b1;
            readAddr = ~ra;
            writeAddr = ~wa;
            if (wr)
            begin
                #100;
                for (i = 0; i < 4; i++)
                begin
                    writeData = b + i[17:0];
                    byteWriteMaskN = m;
                    #100;
                end
                writeData = ~writeData;
                byteWriteMaskN = 2'h3;
            end
        end
    endtask
    task stop_clk;
        begin
            @(posedge clkTrue);
            run = 1'b0;
            #300;
            run = 1'b1;
        end
    endtask
endmodule // memctl_model

// >>> verification/qdr_sram_ctrl_tb.sv
`timescale 1ns/1ps
module qdr_sram_ctrl_tb;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg dllDisableN = 1'b1;
    reg terminationSelect = 1'b1;
    wire clkTrue, clkComp, readSelN, writeSelN, readValidFlag, echoClockTrue, echoClockComp;
    wire impSettled, dllLocked, deviceReady, writeOverflow;
    wire [7:0] readAddr, writeAddr;
    wire [17:0] writeData, readData;
    wire [1:0] optClkLevel, optDataLevel;
    wire [1:0] byteWriteMaskN, termClkLevel, termDataLevel;
    wire [3:0] impCode;
    integer fail_count = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer flagRises = 0;
    reg [17:0] expQ[$];
    realtime lat = 0.0;
    memctl_model mc(.clkTrue(clkTrue), .clkComp(clkComp), .readSelN(readSelN),
        .writeSelN(writeSelN), .readAddr(readAddr), .writeAddr(writeAddr),
        .writeData(writeData), .byteWriteMaskN(byteWriteMaskN));
    qdr_sram_ctrl #(.LOCK_COUNT(16), .STOP_COUNT(8)) dut(.core_clk(core_clk), .rst_n(rst_n),
        .clkTrue(clkTrue), .clkComp(clkComp), .readSelN(readSelN), .writeSelN(writeSelN),
        .readAddr(readAddr), .writeAddr(writeAddr), .writeData(writeData),
        .byteWriteMaskN(byteWriteMaskN), .dllDisableN(dllDisableN),
        .terminationSelect(terminationSelect), .readData(readData),
        .readValidFlag(readValidFlag), .echoClockTrue(echoClockTrue),
        .echoClockComp(echoClockComp), .impCode(impCode), .impSettled(impSettled),
        .termClkLevel(termClkLevel), .termDataLevel(termDataLevel), .dllLocked(dllLocked),
        .deviceReady(deviceReady), .writeOverflow(writeOverflow));
    // second copy built for the other termination option
    qdr_sram_ctrl #(.LOCK_COUNT(16), .STOP_COUNT(8), .TERM_OPTION2(1)) dut2(
        .core_clk(core_clk), .rst_n(rst_n), .clkTrue(clkTrue), .clkComp(clkComp),
        .readSelN(readSelN), .writeSelN(writeSelN), .readAddr(readAddr),
        .writeAddr(writeAddr), .writeData(writeData), .byteWriteMaskN(byteWriteMaskN),
        .dllDisableN(dllDisableN), .terminationSelect(terminationSelect), .readData(),
        .readValidFlag(), .echoClockTrue(), .echoClockComp(), .impCode(), .impSettled(),
        .termClkLevel(optClkLevel), .termDataLevel(optDataLevel), .dllLocked(),
        .deviceReady(), .writeOverflow());
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    task check(input [17:0] seen, input [17:0] exp);
        begin
            checks_done++;
            if (seen !== exp)
            begin
                fail_count++;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test;
        end
    end
    always @(posedge readValidFlag)
    begin
        flagRises++;
        lat = $realtime - mc.cmdTime;
        repeat (4)
        begin
            @(echoClockTrue);
            repeat (2) @(posedge core_clk);
            check(readData, expQ.pop_front());
        end
    end
    task expect4(input [17:0] b);
        integer i;
        begin
            for (i = 0; i < 4; i++)
                expQ.push_back(b + i[17:0]);
        end
    endtask
    task wait_empty;
        integer n;
        begin
            n = 0;
            while (expQ.size() != 0 && n < 400)
            begin
                @(negedge core_clk);
                n++;
            end
            check(expQ.size() == 0, 1'b1);
            expQ.delete();
        end
    endtask
    task wait_lock;
        integer n;
        begin
            n = 0;
            while (!(dllLocked === 1'b1 && deviceReady === 1'b1) && n < 3000)
            begin
                @(negedge core_clk);
                n++;
            end
            check(dllLocked, 1'b1);
        end
    endtask
    task t_init;
        begin
            check(impCode, 4'h8);
            repeat (8300) @(negedge core_clk);
            check({impSettled, impCode}, 5'h1f);
            check(deviceReady, 1'b1);
        end
    endtask
    task t_term;
        integer i;
        begin
            for (i = 0; i < 2; i++)
            begin
                terminationSelect = i[0];
                repeat (6) @(negedge core_clk);
                check(termClkLevel, i ? 2'h1 : 2'h2);
                check(termDataLevel, i ? 2'h1 : 2'h2);
                check(optClkLevel, 2'h0);
                check(optDataLevel, i ? 2'h1 : 2'h0);
            end
        end
    endtask
    // write buffer seen through the top
    task t_fifo;
        begin
            mc.cmd(1'b0, 1'b1, 8'h0, 8'h20, 18'h0c1a0, 2'h0);
            check(writeOverflow, 1'b0);
            check(echoClockComp ^ echoClockTrue, 1'b1);
            expect4(18'h0c1a0);
            mc.cmd(1'b1, 1'b0, 8'h20, 8'h0, 18'h0, 2'h3);
            wait_empty;
        end
    endtask
    task t_data;
        integer r;
        begin
            mc.cmd(1'b0, 1'b1, 8'h0, 8'h05, 18'h2a400, 2'h0);
            expect4(18'h2a400);
            mc.cmd(1'b1, 1'b1, 8'h05, 8'h09, 18'h15033, 2'h0);
            wait_empty;
            mc.cmd(1'b0, 1'b1, 8'h0, 8'h05, 18'h15033, 2'h2);
            r = flagRises;
            expect4(18'h2a433);
            mc.cmd(1'b1, 1'b0, 8'h05, 8'h0, 18'h0, 2'h3);
            mc.cmd(1'b1, 1'b0, 8'h05, 8'h0, 18'h0, 2'h3);
            wait_empty;
            repeat (60) @(negedge core_clk);
            check(flagRises - r == 1, 1'b1);
            expect4(18'h15033);
            mc.cmd(1'b1, 1'b0, 8'h09, 8'h0, 18'h0, 2'h3);
            wait_empty;
        end
    endtask
    task t_bypass;
        realtime ln;
        begin
            ln = lat;
            dllDisableN = 1'b0;
            repeat (8) @(negedge core_clk);
            check(dllLocked, 1'b0);
            expect4(18'h15033);
            mc.cmd(1'b1, 1'b0, 8'h09, 8'h0, 18'h0, 2'h3);
            wait_empty;
            check(ln - lat > 250.0 && ln - lat < 350.0, 1'b1);
            dllDisableN = 1'b1;
            wait_lock;
            mc.stop_clk;
            @(negedge core_clk);
            check(dllLocked, 1'b0);
            wait_lock;
            expect4(18'h2a433);
            mc.cmd(1'b1, 1'b0, 8'h05, 8'h0, 18'h0, 2'h3);
            wait_empty;
        end
    endtask
    initial
    begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        t_init;
        t_term;
        t_fifo;
        t_data;
        @(negedge core_clk);
        t_bypass;
        end_of_test;
    end
endmodule // qdr_sram_ctrl_tb
